// ==== rtl/ccn_pkg.sv ====
// Constants, types and address map of the clock network control block
package ccn_pkg;

  localparam int NUM_GLB   = 16;
  localparam int NUM_RGN   = 32;
  localparam int NUM_QUAD  = 4;
  localparam int RGN_PER_Q = 8;
  localparam int NUM_POUT  = 4;
  localparam int NUM_PIN   = 12;
  localparam int NUM_PLL   = 8;
  localparam int NUM_CORE  = 4;
  localparam int NUM_SRC   = 32;
  localparam int RES_PER_Q = 24;
  localparam int ROW_PER_Q = 6;
  localparam int LB_CLK    = 3;
  localparam int IO_PER_Q  = 8;
  localparam int IO_HALF   = 4;
  localparam int SW        = 5;
  localparam int LW        = 3;
  localparam int DW        = 32;
  localparam int AW        = 8;

  // Source index space of the global, regional and output selectors; limits of the quadrant selectors
  localparam logic [SW-1:0] SRC_PIN       = 5'h00;
  localparam logic [SW-1:0] PIN_SIDE      = 5'h08;
  localparam logic [SW-1:0] SRC_C0        = 5'h0C;
  localparam logic [SW-1:0] SRC_C1        = 5'h14;
  localparam logic [SW-1:0] SRC_CORE      = 5'h1C;
  localparam logic [LW-1:0] PLL_CENTER    = 3'h4;
  localparam logic [LW-1:0] PLL_CORNER    = 3'h6;
  localparam logic [SW-1:0] RES_LIMIT     = 5'h18;
  localparam logic [LW-1:0] ROW_LIMIT     = 3'h6;

  // Unit configuration fields
  localparam int G_SEL  = 0;
  localparam int G_CA   = 5;
  localparam int G_CB   = 10;
  localparam int G_DYN  = 15;
  localparam int G_PD   = 16;
  localparam int GCFG_W = 17;
  localparam int R_SEL  = 0;
  localparam int R_DUAL = 5;
  localparam int R_PD   = 7;
  localparam int RCFG_W = 8;
  localparam int P_SEL  = 0;
  localparam int P_PD   = 5;
  localparam int P_PIN  = 6;
  localparam int PCFG_W = 7;
  localparam int ROW_W  = 30;
  localparam int LBS_W  = 9;
  localparam int IOS_W  = 40;
  localparam int IOH_W  = 20;

  // Every network starts powered down until software configures it
  localparam logic [GCFG_W-1:0] GCFG_RST = 17'h1_0000;
  localparam logic [RCFG_W-1:0] RCFG_RST = 8'h80;
  localparam logic [PCFG_W-1:0] PCFG_RST = 7'h20;

  localparam logic [1:0] DUAL_NONE  = 2'h0;
  localparam logic [1:0] DUAL_HORIZ = 2'h1;
  localparam logic [1:0] DUAL_VERT  = 2'h2;

  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_STAT = 8'h01;
  localparam logic [AW-1:0] A_GEN  = 8'h02;
  localparam logic [AW-1:0] A_REN  = 8'h03;
  localparam logic [AW-1:0] A_PEN  = 8'h04;
  localparam logic [AW-1:0] A_GCFG = 8'h10;
  localparam logic [AW-1:0] A_RCFG = 8'h20;
  localparam logic [AW-1:0] A_PCFG = 8'h40;
  localparam logic [AW-1:0] A_ROW  = 8'h48;
  localparam logic [AW-1:0] A_LBS  = 8'h4C;
  localparam logic [AW-1:0] A_IOS  = 8'h50;
  localparam int CTRL_USER = 0;
  localparam int STAT_REF  = 0;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK  = 2'h2
  } ccn_bus_type;

endpackage

// ==== rtl/ccn_sync.sv ====
// Two-flop synchroniser for clock sources sampled as levels
`timescale 1ns/1ps
module ccn_sync #(
  parameter int W = 1
) (
  input  logic         ref_clk,
  input  logic         rstn,
  input  logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } ccn_sync_state_type;

  ccn_sync_state_type q;
  ccn_sync_state_type d;

  always_comb begin
    d      = q;
    d.meta = async_in;
    d.stab = q.meta;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stab;

endmodule // ccn_sync

// ==== rtl/ccn_clock_ctrl.sv ====
// Clock network control: source selection, gating and quadrant muxes
`timescale 1ns/1ps
module ccn_clock_ctrl
  import ccn_pkg::*;
(
  input  logic                 ref_clk,
  input  logic                 rstn,
  input  logic [AW-1:0]        avs_address,
  input  logic                 avs_read,
  input  logic                 avs_write,
  input  logic [DW-1:0]        avs_writedata,
  output logic [DW-1:0]        avs_readdata,
  output logic                 avs_waitrequest,
  input  logic [NUM_PIN-1:0]   dedicated_clock_input_pin,
  input  logic [NUM_PLL-1:0]   pll_counter_output_zero,
  input  logic [NUM_PLL-1:0]   pll_counter_output_one,
  input  logic [NUM_CORE-1:0]  core_clock_drive,
  input  logic [NUM_GLB-1:0]   glb_dyn_sel,
  input  logic [NUM_GLB-1:0]   glb_ena,
  input  logic [NUM_RGN-1:0]   rgn_ena,
  input  logic [NUM_POUT-1:0]  pout_ena,
  input  logic [NUM_POUT-1:0]  pout_user,
  output logic [NUM_GLB-1:0]   global_clock_line,
  output logic [NUM_RGN-1:0]   regional_clock_line,
  output logic [NUM_POUT-1:0]  pll_out_pin,
  output logic [RES_PER_Q-1:0] row_clock,
  output logic [11:0]          logic_block_clock,
  output logic [NUM_RGN-1:0]   io_element_clock
);

  typedef struct packed {
    ccn_bus_type                          bus;
    logic                                 wait_n;
    logic [DW-1:0]                        rdata;
    logic                                 user;
    logic                                 refused;
    logic [NUM_GLB-1:0][GCFG_W-1:0]       gcfg;
    logic [NUM_RGN-1:0][RCFG_W-1:0]       rcfg;
    logic [NUM_POUT-1:0][PCFG_W-1:0]      pcfg;
    logic [NUM_QUAD-1:0][ROW_W-1:0]       rowsel;
    logic [NUM_QUAD-1:0][LBS_W-1:0]       lbsel;
    logic [NUM_QUAD-1:0][IOS_W-1:0]       iosel;
    logic [NUM_GLB-1:0]                   gen;
    logic [NUM_RGN-1:0]                   ren;
    logic [NUM_POUT-1:0]                  pen;
    logic [NUM_GLB-1:0]                   gline;
    logic [NUM_RGN-1:0]                   rline;
    logic [NUM_POUT-1:0]                  ppin;
    logic [NUM_QUAD-1:0][ROW_PER_Q-1:0]   row;
    logic [NUM_QUAD-1:0][LB_CLK-1:0]      lb;
    logic [NUM_QUAD-1:0][IO_PER_Q-1:0]    io;
  } ccn_top_state_type;

  ccn_top_state_type q;
  ccn_top_state_type d;

  logic [NUM_PIN-1:0]  pin_s;
  logic [NUM_PLL-1:0]  c0_s;
  logic [NUM_PLL-1:0]  c1_s;
  logic [NUM_SRC-1:0]  src;
  logic [NUM_GLB-1:0]  raw_g;
  logic [NUM_RGN-1:0]  raw_r;
  logic [NUM_POUT-1:0] raw_p;
  logic [DW-1:0]       rd_word;
  logic                take;
  logic                hit_g;
  logic                hit_r;
  logic                hit_p;
  logic                hit_row;
  logic                hit_lb;
  logic                hit_io;
  logic [3:0]          gidx;
  logic [4:0]          ridx;
  logic [1:0]          pidx;
  logic [1:0]          qidx;
  logic [2:0]          ioff;
  logic                cand_b0;

  // Source clocks come from other domains; sample them as levels
  ccn_sync #(
    .W (NUM_PIN + 2 * NUM_PLL)
  ) u_src_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .async_in ({pll_counter_output_one, pll_counter_output_zero,
                dedicated_clock_input_pin}),
    .sync_out ({c1_s, c0_s, pin_s})
  );

  // Core drivers share ref_clk and need no synchroniser
  assign src = {core_clock_drive, c1_s, c0_s, pin_s};

  function automatic logic res_pick(input logic [RES_PER_Q-1:0] r,
                                    input logic [SW-1:0]        s);
    res_pick = (s < RES_LIMIT) ? r[s] : 1'b0;
  endfunction

  function automatic logic is_dyn_cand(input logic [SW-1:0] s);
    is_dyn_cand = (s < SRC_CORE);
  endfunction

  // Legal regional source for a given dual-regional mode
  function automatic logic rgn_ok(input logic [SW-1:0] s,
                                  input logic [1:0]    dual);
    logic           is_pll;
    logic [LW-1:0]  pll;
    is_pll = (s >= SRC_C0) && (s < SRC_CORE);
    pll    = LW'(s - SRC_C0);
    rgn_ok = !((s >= PIN_SIDE) && (s < SRC_C0));
    if (dual == DUAL_HORIZ) begin
      rgn_ok = rgn_ok && ((s < PIN_SIDE) || (is_pll &&
               (pll >= PLL_CENTER) && (pll < PLL_CORNER)));
    end else if (dual == DUAL_VERT) begin
      rgn_ok = rgn_ok && is_pll && (pll < PLL_CENTER);
    end else if (dual != DUAL_NONE) begin
      rgn_ok = 1'b0;
    end
  endfunction

  assign take = (q.bus == BUS_IDLE) && (avs_read || avs_write);

  assign hit_g   = (avs_address >= A_GCFG) &&
                   (avs_address < A_GCFG + NUM_GLB);
  assign hit_r   = (avs_address >= A_RCFG) &&
                   (avs_address < A_RCFG + NUM_RGN);
  assign hit_p   = (avs_address >= A_PCFG) &&
                   (avs_address < A_PCFG + NUM_POUT);
  assign hit_row = (avs_address >= A_ROW) &&
                   (avs_address < A_ROW + NUM_QUAD);
  assign hit_lb  = (avs_address >= A_LBS) &&
                   (avs_address < A_LBS + NUM_QUAD);
  assign hit_io  = (avs_address >= A_IOS) &&
                   (avs_address < A_IOS + 2 * NUM_QUAD);
  assign gidx    = 4'(avs_address - A_GCFG);
  assign ridx    = 5'(avs_address - A_RCFG);
  assign pidx    = 2'(avs_address - A_PCFG);
  assign ioff    = 3'(avs_address - A_IOS);
  assign qidx    = hit_row ? 2'(avs_address - A_ROW) :
                   hit_lb  ? 2'(avs_address - A_LBS) : 2'(ioff >> 1);

  always_comb begin
    rd_word = '0;
    if (avs_address == A_CTRL) begin
      rd_word[CTRL_USER] = q.user;
    end else if (avs_address == A_STAT) begin
      rd_word[STAT_REF] = q.refused;
    end else if (avs_address == A_GEN) begin
      rd_word = DW'(q.gen);
    end else if (avs_address == A_REN) begin
      rd_word = q.ren;
    end else if (avs_address == A_PEN) begin
      rd_word = DW'(q.pen);
    end else if (hit_g) begin
      rd_word = DW'(q.gcfg[gidx]);
    end else if (hit_r) begin
      rd_word = DW'(q.rcfg[ridx]);
    end else if (hit_p) begin
      rd_word = DW'(q.pcfg[pidx]);
    end else if (hit_row) begin
      rd_word = DW'(q.rowsel[qidx]);
    end else if (hit_lb) begin
      rd_word = DW'(q.lbsel[qidx]);
    end else if (hit_io) begin
      rd_word = DW'(q.iosel[qidx][ioff[0] * IOH_W +: IOH_W]);
    end
  end

  always_comb begin
    logic [GCFG_W-1:0]    g;
    logic [SW-1:0]        s;
    logic [RES_PER_Q-1:0] res;
    logic                 set;
    logic                 clr;
    g   = '0;
    s   = '0;
    res = '0;
    set = 1'b0;
    clr = 1'b0;
    d   = q;

    // Global units: static or run-time source, then synchronous gate
    for (int i = 0; i < NUM_GLB; i++) begin
      g = q.gcfg[i];
      if (g[G_DYN]) begin
        s = glb_dyn_sel[i] ? g[G_CB +: SW] : g[G_CA +: SW];
      end else begin
        s = g[G_SEL +: SW];
      end
      raw_g[i] = src[s];
      // Enable moves only in the low phase; no runt high pulse
      if (!raw_g[i]) begin
        d.gen[i] = glb_ena[i] & ~g[G_PD];
      end
      d.gline[i] = raw_g[i] & q.gen[i];
    end

    // Regional units; a dual-regional partner lends its source
    for (int j = 0; j < NUM_RGN; j++) begin
      s = q.rcfg[j][R_SEL +: SW];
      if (q.rcfg[j][R_DUAL +: 2] == DUAL_NONE) begin
        if (q.rcfg[j ^ RGN_PER_Q][R_DUAL +: 2] == DUAL_HORIZ) begin
          s = q.rcfg[j ^ RGN_PER_Q][R_SEL +: SW];
        end else if (q.rcfg[j ^ (2 * RGN_PER_Q)][R_DUAL +: 2] ==
                     DUAL_VERT) begin
          s = q.rcfg[j ^ (2 * RGN_PER_Q)][R_SEL +: SW];
        end
      end
      raw_r[j] = src[s];
      if (!raw_r[j]) begin
        d.ren[j] = rgn_ena[j] & ~q.rcfg[j][R_PD];
      end
      d.rline[j] = raw_r[j] & q.ren[j];
    end

    // PLL external output units and the pin's own mux
    for (int k = 0; k < NUM_POUT; k++) begin
      raw_p[k] = src[q.pcfg[k][P_SEL +: SW]];
      if (!raw_p[k]) begin
        d.pen[k] = pout_ena[k] & ~q.pcfg[k][P_PD];
      end
      d.ppin[k] = q.pcfg[k][P_PIN] ? pout_user[k] :
                  (raw_p[k] & q.pen[k]);
    end

    // Quadrant muxes: one register stage per level keeps timing short
    for (int m = 0; m < NUM_QUAD; m++) begin
      res = {q.rline[m * RGN_PER_Q +: RGN_PER_Q], q.gline};
      for (int r = 0; r < ROW_PER_Q; r++) begin
        d.row[m][r] = res_pick(res, q.rowsel[m][r * SW +: SW]);
      end
      for (int b = 0; b < LB_CLK; b++) begin
        d.lb[m][b] = (q.lbsel[m][b * LW +: LW] < ROW_LIMIT) ?
                     q.row[m][q.lbsel[m][b * LW +: LW]] : 1'b0;
      end
      for (int o = 0; o < IO_PER_Q; o++) begin
        d.io[m][o] = res_pick(res, q.iosel[m][o * SW +: SW]);
      end
    end

    // Register bus: one wait cycle, then a single-cycle answer
    if (take) begin
      d.bus    = BUS_ACK;
      d.wait_n = 1'b0;
      d.rdata  = rd_word;
      if (avs_write) begin
        if (avs_address == A_CTRL) begin
          d.user = avs_writedata[CTRL_USER];
        end else if (avs_address == A_STAT) begin
          clr = avs_writedata[STAT_REF];
        end else if (hit_g || hit_r || hit_p ||
                     hit_row || hit_lb || hit_io) begin
          if (q.user) begin
            set = 1'b1;
          end else if (hit_g) begin
            g = avs_writedata[GCFG_W-1:0];
            if (g[G_DYN] && !(is_dyn_cand(g[G_CA +: SW]) &&
                              is_dyn_cand(g[G_CB +: SW]))) begin
              set = 1'b1;
            end else begin
              d.gcfg[gidx] = g;
            end
          end else if (hit_r) begin
            if (!rgn_ok(avs_writedata[R_SEL +: SW],
                        avs_writedata[R_DUAL +: 2])) begin
              set = 1'b1;
            end else begin
              d.rcfg[ridx] = avs_writedata[RCFG_W-1:0];
            end
          end else if (hit_p) begin
            d.pcfg[pidx] = avs_writedata[PCFG_W-1:0];
          end else if (hit_row) begin
            d.rowsel[qidx] = avs_writedata[ROW_W-1:0];
          end else if (hit_lb) begin
            d.lbsel[qidx] = avs_writedata[LBS_W-1:0];
          end else begin
            d.iosel[qidx][ioff[0] * IOH_W +: IOH_W] =
              avs_writedata[IOH_W-1:0];
          end
        end
      end
    end else if (q.bus == BUS_ACK) begin
      d.bus    = BUS_IDLE;
      d.wait_n = 1'b1;
    end
    // A refusal in the clearing cycle still sets the flag
    d.refused = (q.refused & ~clr) | set;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      q        <= '0;
      q.bus    <= BUS_IDLE;
      q.wait_n <= 1'b1;
      q.gcfg   <= {NUM_GLB{GCFG_RST}};
      q.rcfg   <= {NUM_RGN{RCFG_RST}};
      q.pcfg   <= {NUM_POUT{PCFG_RST}};
    end else begin
      q <= d;
    end
  end

  assign avs_readdata        = q.rdata;
  assign avs_waitrequest     = q.wait_n;
  assign global_clock_line   = q.gline;
  assign regional_clock_line = q.rline;
  assign pll_out_pin         = q.ppin;
  assign row_clock           = q.row;
  assign logic_block_clock   = q.lb;
  assign io_element_clock    = q.io;

  assign cand_b0 = src[q.gcfg[0][G_CB +: SW]];

  default clocking cb_main @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_taken;
    take;
  endsequence

  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_answer_once:
    assert property (s_taken |=> s_answer)
    else $error("bus answer not one cycle after request");

  a_line_held_off:
    assert property (!q.gen[0] |=> !global_clock_line[0])
    else $error("disabled global line produced a high level");

  a_enable_low_phase:
    assert property ($changed(q.gen[0]) |-> !$past(raw_g[0]))
    else $error("global enable changed in high phase");

  a_gline_follows:
    assert property (q.gen[0] |=> global_clock_line[0] == $past(raw_g[0]))
    else $error("enabled global line does not follow its source");

  a_rline_follows:
    assert property (q.ren[0] |=> regional_clock_line[0] == $past(raw_r[0]))
    else $error("enabled regional line does not follow its source");

  a_static_pd_blocks:
    assert property ($rose(q.gen[0]) |-> !$past(q.gcfg[0][G_PD]))
    else $error("powered-down global line was enabled");

  a_dyn_select_b:
    assert property (q.gcfg[0][G_DYN] && glb_dyn_sel[0] && q.gen[0]
                     |=> global_clock_line[0] == $past(cand_b0))
    else $error("dynamic select did not pick candidate b");

  a_lock_in_user:
    assert property (take && avs_write && q.user && avs_address == A_RCFG
                     |=> $stable(q.rcfg[0]) && q.refused)
    else $error("regional source changed in user mode");

  a_no_side_pin:
    assert property (!((q.rcfg[0][R_SEL +: SW] >= PIN_SIDE) &&
                       (q.rcfg[0][R_SEL +: SW] < SRC_C0)))
    else $error("regional unit holds a side clock pin");

  a_pin_mode_mux:
    assert property (q.pcfg[0][P_PIN]
                     |=> pll_out_pin[0] == $past(pout_user[0]))
    else $error("output pin did not carry the internal signal");

endmodule // ccn_clock_ctrl

// ==== sim/ccn_src_model.sv ====
// Clock source model: dedicated pins, PLL outputs and core drivers
`timescale 1ns/1ps
module ccn_src_model
  import ccn_pkg::*;
(
  input  logic                ref_clk,
  input  logic                rstn,
  output logic [NUM_PIN-1:0]  pin,
  output logic [NUM_PLL-1:0]  pll_zero,
  output logic [NUM_PLL-1:0]  pll_one,
  output logic [NUM_CORE-1:0] core
);
  logic [4:0] cnt_q;

  // PLL outputs keep running whatever the gates downstream do
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Distinct rates let the bench tell sources apart by edge count
  assign pin      = {NUM_PIN{cnt_q[2]}};
  assign pll_zero = {NUM_PLL{cnt_q[3]}};
  assign pll_one  = {NUM_PLL{cnt_q[4]}};
  assign core     = {NUM_CORE{cnt_q[1]}};
endmodule // ccn_src_model

// ==== sim/ccn_clock_ctrl_tb.sv ====
// Self-checking bench for the clock network control block
`timescale 1ns/1ps
module ccn_clock_ctrl_tb;
  import ccn_pkg::*;
  typedef struct {
    logic [AW-1:0] a;
    logic [DW-1:0] d;
    int            o;
    int            n;
  } ccn_row_type;

  logic                 ref_clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [AW-1:0]        avs_address;
  logic [DW-1:0]        avs_writedata, avs_readdata, rd;
  logic [NUM_PIN-1:0]   pin;
  logic [NUM_PLL-1:0]   pz, po;
  logic [NUM_CORE-1:0]  core;
  logic [NUM_GLB-1:0]   glb_dyn_sel, glb_ena, gl;
  logic [NUM_RGN-1:0]   rgn_ena, rl, io;
  logic [NUM_POUT-1:0]  pout_ena, pout_user, pp;
  logic [RES_PER_Q-1:0] rc;
  logic [11:0]          lb;
  logic [119:0]         obs;
  int                   errors, check_count;
  ccn_row_type          rows [16];

  // One flat view of every clock output, indexed by the table rows
  assign obs = {io, lb, rc, pp, rl, gl};

  ccn_src_model src (
    .ref_clk(ref_clk), .rstn(rstn), .pin(pin), .pll_zero(pz),
    .pll_one(po), .core(core)
  );

  ccn_clock_ctrl DUT (
    .ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dedicated_clock_input_pin(pin),
    .pll_counter_output_zero(pz), .pll_counter_output_one(po),
    .core_clock_drive(core), .glb_dyn_sel(glb_dyn_sel),
    .glb_ena(glb_ena), .rgn_ena(rgn_ena), .pout_ena(pout_ena),
    .pout_user(pout_user), .global_clock_line(gl),
    .regional_clock_line(rl), .pll_out_pin(pp), .row_clock(rc),
    .logic_block_clock(lb), .io_element_clock(io)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check_word(input logic [DW-1:0] got,
                            input logic [DW-1:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_edges(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      errors++;
      $display("Error at %0t: %0d edges, expected %0d", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [AW-1:0] a,
                     input logic [DW-1:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 50) begin
      errors++;
      $display("Error at %0t: no bus answer", $time);
      final_report;
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Settle long enough for the slowest source to pass a low phase
  task automatic edges(input int o, output int n);
    logic p;
    n = 0;
    repeat (40) @(posedge ref_clk);
    p = obs[o];
    repeat (64) begin
      @(posedge ref_clk);
      if (p === 1'b0 && obs[o] === 1'b1) n++;
      p = obs[o];
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge ref_clk);
    $display("Error at %0t: watchdog expired", $time);
    errors++;
    final_report;
  end

  initial begin
    int n;
    rstn = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    glb_dyn_sel = 16'h0000;
    glb_ena = 16'hFFFF;
    rgn_ena = 32'hFFFF_FFFF;
    pout_ena = 4'hF;
    pout_user = 4'h0;
    errors = 0;
    check_count = 0;
    rows = '{
      '{8'h10, 32'h0000_0000, 0, 8},
      '{8'h11, 32'h0000_000C, 1, 4},
      '{8'h12, 32'h0000_0014, 2, 2},
      '{8'h13, 32'h0000_001C, 3, 16},
      '{8'h14, 32'h0001_0000, 4, 0},
      '{8'h20, 32'h0000_0001, 16, 8},
      '{8'h21, 32'h0000_0009, 17, 0},
      '{8'h2A, 32'h0000_000C, 26, 4},
      '{8'h22, 32'h0000_0022, 26, 8},
      '{8'h24, 32'h0000_0032, 20, 0},
      '{8'h40, 32'h0000_000C, 48, 4},
      '{8'h48, 32'h0000_0003, 52, 16},
      '{8'h4C, 32'h0000_0006, 76, 0},
      '{8'h4C, 32'h0000_0000, 76, 16},
      '{8'h50, 32'h0000_0002, 88, 2},
      '{8'h10, 32'h0000_F000, 0, 8}
    };
    repeat (15) @(posedge ref_clk);
    check_word(DW'(gl), 32'h0000_0000);
    check_word(DW'(avs_waitrequest), 32'h0000_0001);
    @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    bus(1'b0, 8'h15, 32'h0000_0000);
    check_word(rd, 32'h0001_0000);
    bus(1'b0, 8'h22, 32'h0000_0000);
    check_word(rd, 32'h0000_0080);
    bus(1'b0, 8'h41, 32'h0000_0020);
    check_word(rd, 32'h0000_0020);
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      edges(rows[i].o, n);
      check_edges(n, rows[i].n);
    end
    $display("test table done");
    bus(1'b1, 8'h10, 32'h0000_B000);
    edges(0, n);
    check_edges(n, 8);
    glb_dyn_sel[0] <= 1'b1;
    edges(0, n);
    check_edges(n, 4);
    glb_ena[0] <= 1'b0;
    edges(0, n);
    check_edges(n, 0);
    glb_ena[0] <= 1'b1;
    edges(0, n);
    check_edges(n, 4);
    $display("test run-time control done");
    bus(1'b0, 8'h01, 32'h0000_0000);
    check_word(rd, 32'h0000_0001);
    bus(1'b1, 8'h01, 32'h0000_0001);
    bus(1'b0, 8'h01, 32'h0000_0000);
    check_word(rd, 32'h0000_0000);
    pout_user <= 4'h1;
    bus(1'b1, 8'h40, 32'h0000_004C);
    repeat (8) @(posedge ref_clk);
    check_word(DW'(pp[0]), 32'h0000_0001);
    pout_user <= 4'h0;
    repeat (3) @(posedge ref_clk);
    check_word(DW'(pp[0]), 32'h0000_0000);
    $display("test status and pin mux done");
    bus(1'b1, 8'h00, 32'h0000_0001);
    bus(1'b1, 8'h11, 32'h0000_001C);
    edges(1, n);
    check_edges(n, 4);
    bus(1'b0, 8'h01, 32'h0000_0000);
    check_word(rd, 32'h0000_0001);
    bus(1'b1, 8'h20, 32'h0000_000C);
    bus(1'b0, 8'h20, 32'h0000_0000);
    check_word(rd, 32'h0000_0001);
    bus(1'b0, 8'h7F, 32'h0000_0000);
    check_word(rd, 32'h0000_0000);
    $display("test lock done");
    final_report;
  end
endmodule // ccn_clock_ctrl_tb
